/* File: logic/rtcr_defs.svh */
`ifndef RTCR_DEFS_SVH
`define RTCR_DEFS_SVH

// Register byte offsets (address bits 13:0)
`define RTCR_OFS_CONFIG     14'h0000
`define RTCR_OFS_IRQ_STATUS 14'h0004
`define RTCR_OFS_IRQ_MASK   14'h0008
`define RTCR_OFS_LAST_SW    14'h000C
`define RTCR_OFS_LAST_INFO  14'h0010
`define RTCR_RAM_SEL_BIT    13

// Configuration bits
`define RTCR_CFG_BROADCAST_FLAG_DIS  0
`define RTCR_CFG_ILL_EN     1
`define RTCR_CFG_ACC_IRQ    2
`define RTCR_CFG_BC_IRQ     3
`define RTCR_CFG_IXZ        4
`define RTCR_CFG_RESET      5'h00

// Interrupt status / mask bits
`define RTCR_IRQ_APF        0
`define RTCR_IRQ_ILLEGAL    1
`define RTCR_IRQ_ACCESS     2
`define RTCR_IRQ_BROADCAST_FLAG      3
`define RTCR_IRQ_IXZ        4
`define RTCR_IRQ_MSG_ERR    5
`define RTCR_IRQ_W          6

// RAM word regions
`define RTCR_DESC_BASE      11'h000
`define RTCR_INFO_BASE      11'h040
`define RTCR_ILL_BASE       11'h080
`define RTCR_TMP_BASE       11'h100
`define RTCR_BUF_BASE       11'h400

// Descriptor control word fields
`define RTCR_DESC_ACC       0
`define RTCR_DESC_PPB       1
`define RTCR_DESC_BROADCAST_FLAG     2
`define RTCR_DESC_IDX_LO    8
`define RTCR_DESC_IDX_HI    15
`define RTCR_DESC_BUF_LO    16
`define RTCR_DESC_BUF_HI    20

// Message info word fields
`define RTCR_INFO_MSG_ERR   0
`define RTCR_INFO_ILLEGAL   1
`define RTCR_INFO_T2T       2
`define RTCR_INFO_BUS_ID    3
`define RTCR_INFO_BROADCAST_FLAG     4

// Status word fields and command word values
`define RTCR_SW_MSG_ERR     10
`define RTCR_SW_BC_RCVD     4
`define RTCR_BROADCAST_FLAG_ADDR     5'h1F
`define RTCR_SA_MODE0       5'h00
`define RTCR_SA_MODE31      5'h1F
`endif

/* File: logic/rtcr_pkg.sv */
package rtcr_pkg;
  typedef enum logic [12:0] {
    S_IDLE   = 13'b0_0000_0000_0001,
    S_RDESC  = 13'b0_0000_0000_0010,
    S_RILL   = 13'b0_0000_0000_0100,
    S_DECIDE = 13'b0_0000_0000_1000,
    S_TXST   = 13'b0_0000_0001_0000,
    S_TXRD   = 13'b0_0000_0010_0000,
    S_TXLD   = 13'b0_0000_0100_0000,
    S_TXDW   = 13'b0_0000_1000_0000,
    S_RXDAT  = 13'b0_0001_0000_0000,
    S_CPRD   = 13'b0_0010_0000_0000,
    S_CPWR   = 13'b0_0100_0000_0000,
    S_WDESC  = 13'b0_1000_0000_0000,
    S_WINFO  = 13'b1_0000_0000_0000
  } rtcr_state_e;
  typedef logic [10:0] rtcr_addr_t;
endpackage

/* File: logic/rtcr_ram.sv */
`timescale 1ns/1ps
module rtcr_ram (
  input  wire logic              mclk_in,
  input  wire rtcr_pkg::rtcr_addr_t a_addr_in,
  input  wire logic              a_we_in,
  input  wire logic [31:0]       a_wdata_in,
  output logic [31:0]            a_rdata_out,
  input  wire rtcr_pkg::rtcr_addr_t b_addr_in,
  input  wire logic              b_we_in,
  input  wire logic [31:0]       b_wdata_in,
  output logic [31:0]            b_rdata_out
);
  logic [31:0] mem [0:2047];

  // Engine port written last so it wins a same-address collision
  always_ff @(posedge mclk_in) begin
    if (a_we_in) begin
      mem[a_addr_in] <= a_wdata_in;
    end
    if (b_we_in) begin
      mem[b_addr_in] <= b_wdata_in;
    end
    a_rdata_out <= mem[a_addr_in];
    b_rdata_out <= mem[b_addr_in];
  end
endmodule // rtcr_ram

/* File: logic/rtcr_top.sv */
`timescale 1ns/1ps
`include "rtcr_defs.svh"
module rtcr_top (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [4:0]  terminal_address_inputs_in,
  input  wire logic        terminal_address_parity_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [15:0] cmd_word_in,
  input  wire logic        cmd_error_in,
  input  wire logic        bus_identifier_in,
  input  wire logic        rx_valid_in,
  input  wire logic [15:0] rx_word_in,
  input  wire logic        msg_done_in,
  output logic             tx_valid_out,
  output logic [15:0]      tx_word_out,
  input  wire logic        tx_ready_in,
  output logic             irq_out
);
  rtcr_pkg::rtcr_state_e state_r;
  rtcr_pkg::rtcr_addr_t  a_addr;
  rtcr_pkg::rtcr_addr_t  b_addr;
  logic [31:0]           a_rdata;
  logic [31:0]           b_rdata;
  logic [31:0]           b_wdata;
  logic                  a_we;
  logic                  b_we;
  logic [4:0]            ta_s1_r, ta_s2_r;
  logic                  tp_s1_r, tp_s2_r, apf_q_r;
  logic                  apf_fail, ev_apf;
  logic [4:0]            cfg_r;
  logic [5:0]            mask_r, sts_r, sts_set;
  logic                  irq_r;
  logic                  dph_r, wr_r, size_ok_r, hready_r, hresp_r;
  logic [13:0]           addr_r;
  logic [31:0]           hrdata_r, rd_mux;
  logic                  act, rd_clr;
  logic [15:0]           cmd_r, status_word_r, info_r, tx_word_r;
  logic [31:0]           desc_r, desc_nxt;
  logic                  broadcast_flag_r, illegal_r, tx_valid_r, ixz_hit_r;
  logic [5:0]            idx_r;
  logic                  illegal_now, accept, last_word;
  logic [4:0]            buf_sel;

  function automatic rtcr_pkg::rtcr_addr_t ram_at(input rtcr_pkg::rtcr_addr_t base,
                                                  input logic [9:0] off);
    ram_at = base | {1'b0, off};
  endfunction

  function automatic logic [5:0] nwords(input logic [4:0] wc);
    nwords = (wc == 5'h00) ? 6'h20 : {1'b0, wc};
  endfunction

  function automatic logic [15:0] sw_fn(input logic [4:0] adr, input logic err, input logic brx);
    sw_fn = {adr, err, 5'h00, brx, 4'h0};
  endfunction

  function automatic logic [15:0] info_fn(input logic msg_error_info_flag, input logic ill,
                                          input logic bid, input logic bc);
    info_fn = 16'h0000;
    info_fn[`RTCR_INFO_MSG_ERR] = msg_error_info_flag;
    info_fn[`RTCR_INFO_ILLEGAL] = ill;
    info_fn[`RTCR_INFO_BUS_ID]  = bid;
    info_fn[`RTCR_INFO_BROADCAST_FLAG] = bc;
  endfunction

  rtcr_ram u_ram (
    .mclk_in     (mclk_in),
    .a_addr_in   (a_addr),
    .a_we_in     (a_we),
    .a_wdata_in  (hwdata_in),
    .a_rdata_out (a_rdata),
    .b_addr_in   (b_addr),
    .b_we_in     (b_we),
    .b_wdata_in  (b_wdata),
    .b_rdata_out (b_rdata)
  );

  // Address straps come from pins: two-stage synchronisers
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ta_s1_r <= 5'h00;
      ta_s2_r <= 5'h00;
      // Reset to a good parity code so no false failure edge follows reset
      tp_s1_r <= 1'b1;
      tp_s2_r <= 1'b1;
      apf_q_r <= 1'b0;
    end else begin
      ta_s1_r <= terminal_address_inputs_in;
      ta_s2_r <= ta_s1_r;
      tp_s1_r <= terminal_address_parity_in;
      tp_s2_r <= tp_s1_r;
      apf_q_r <= apf_fail;
    end
  end
  // Odd parity expected over address and parity bit
  assign apf_fail = ~^{ta_s2_r, tp_s2_r};
  assign ev_apf   = apf_fail & ~apf_q_r;

  // AHB-Lite slave: one wait state on every transfer
  assign act    = dph_r & ~hready_r;
  assign rd_clr = act & ~wr_r & size_ok_r & (addr_r == `RTCR_OFS_IRQ_STATUS);
  assign a_we   = act & wr_r & size_ok_r & addr_r[`RTCR_RAM_SEL_BIT];
  assign a_addr = a_we ? addr_r[12:2] : haddr_in[12:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_r[`RTCR_RAM_SEL_BIT]) begin
      rd_mux = a_rdata;
    end else begin
      unique case (addr_r)
        `RTCR_OFS_CONFIG:     rd_mux = {27'h000_0000, cfg_r};
        `RTCR_OFS_IRQ_STATUS: rd_mux = {26'h000_0000, sts_r};
        `RTCR_OFS_IRQ_MASK:   rd_mux = {26'h000_0000, mask_r};
        `RTCR_OFS_LAST_SW:    rd_mux = {16'h0000, status_word_r};
        `RTCR_OFS_LAST_INFO:  rd_mux = {16'h0000, info_r};
        default:              rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dph_r     <= 1'b0;
      wr_r      <= 1'b0;
      size_ok_r <= 1'b0;
      addr_r    <= 14'h0000;
      hready_r  <= 1'b1;
      hrdata_r  <= 32'h0000_0000;
      hresp_r   <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
      if (hsel_in && htrans_in[1] && hready_in) begin
        dph_r     <= 1'b1;
        wr_r      <= hwrite_in;
        size_ok_r <= (hsize_in == 3'h2);
        addr_r    <= {haddr_in[13:2], 2'b00};
        hready_r  <= 1'b0;
      end else if (act) begin
        dph_r    <= 1'b0;
        hready_r <= 1'b1;
        hrdata_r <= wr_r ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_r  <= `RTCR_CFG_RESET;
      mask_r <= 6'h00;
    end else if (act && wr_r && size_ok_r) begin
      if (addr_r == `RTCR_OFS_CONFIG) begin
        cfg_r <= hwdata_in[4:0];
      end
      if (addr_r == `RTCR_OFS_IRQ_MASK) begin
        mask_r <= hwdata_in[5:0];
      end
    end
  end

  // Sticky interrupt status; a new event wins over the read-clear
  always_comb begin
    sts_set = 6'h00;
    sts_set[`RTCR_IRQ_APF]    = ev_apf;
    if (state_r == rtcr_pkg::S_WINFO) begin
      sts_set[`RTCR_IRQ_ILLEGAL] = illegal_r;
      sts_set[`RTCR_IRQ_ACCESS]  = cfg_r[`RTCR_CFG_ACC_IRQ];
      sts_set[`RTCR_IRQ_BROADCAST_FLAG]   = cfg_r[`RTCR_CFG_BC_IRQ] & broadcast_flag_r;
      sts_set[`RTCR_IRQ_IXZ]    = cfg_r[`RTCR_CFG_IXZ] & ixz_hit_r;
      sts_set[`RTCR_IRQ_MSG_ERR] = info_r[`RTCR_INFO_MSG_ERR];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sts_r <= 6'h00;
      irq_r <= 1'b0;
    end else begin
      sts_r <= sts_set | (rd_clr ? 6'h00 : sts_r);
      // Parity failure bypasses the mask
      irq_r <= |(sts_r & (mask_r | 6'h01));
    end
  end

  // Command acceptance and response engine
  assign accept = cmd_valid_in & ~cmd_error_in & ~apf_fail
                & (cmd_word_in[9:5] != `RTCR_SA_MODE0)
                & (cmd_word_in[9:5] != `RTCR_SA_MODE31)
                & ((cmd_word_in[15:11] == ta_s2_r)
                   | ((cmd_word_in[15:11] == `RTCR_BROADCAST_FLAG_ADDR)
                      & ~cfg_r[`RTCR_CFG_BROADCAST_FLAG_DIS]));
  assign illegal_now = cfg_r[`RTCR_CFG_ILL_EN] & b_rdata[cmd_r[9:5]];
  assign buf_sel     = desc_r[`RTCR_DESC_BUF_HI:`RTCR_DESC_BUF_LO];
  assign last_word   = (idx_r == nwords(cmd_r[4:0]) - 6'h01);

  always_comb begin
    desc_nxt = desc_r;
    desc_nxt[`RTCR_DESC_ACC]   = 1'b1;
    desc_nxt[`RTCR_DESC_PPB]   = ~desc_r[`RTCR_DESC_PPB];
    desc_nxt[`RTCR_DESC_BROADCAST_FLAG] = broadcast_flag_r;
    if (desc_r[`RTCR_DESC_IDX_HI:`RTCR_DESC_IDX_LO] != 8'h00) begin
      desc_nxt[`RTCR_DESC_IDX_HI:`RTCR_DESC_IDX_LO] =
        desc_r[`RTCR_DESC_IDX_HI:`RTCR_DESC_IDX_LO] - 8'h01;
    end
  end

  always_comb begin
    b_addr  = 11'h000;
    b_we    = 1'b0;
    b_wdata = 32'h0000_0000;
    unique case (state_r)
      rtcr_pkg::S_RDESC: b_addr = ram_at(`RTCR_DESC_BASE, {4'h0, cmd_r[10:5]});
      rtcr_pkg::S_RILL:  b_addr = ram_at(`RTCR_ILL_BASE, {9'h000, cmd_r[10]});
      rtcr_pkg::S_RXDAT: begin
        b_addr  = ram_at(`RTCR_TMP_BASE, {5'h00, idx_r[4:0]});
        b_we    = rx_valid_in & ~illegal_r & (idx_r < nwords(cmd_r[4:0]));
        b_wdata = {16'h0000, rx_word_in};
      end
      rtcr_pkg::S_TXRD:  b_addr = ram_at(`RTCR_BUF_BASE, {buf_sel, idx_r[4:0]});
      rtcr_pkg::S_CPRD:  b_addr = ram_at(`RTCR_TMP_BASE, {5'h00, idx_r[4:0]});
      rtcr_pkg::S_CPWR: begin
        b_addr  = ram_at(`RTCR_BUF_BASE, {buf_sel, idx_r[4:0]});
        b_we    = 1'b1;
        b_wdata = b_rdata;
      end
      rtcr_pkg::S_WDESC: begin
        b_addr  = ram_at(`RTCR_DESC_BASE, {4'h0, cmd_r[10:5]});
        b_we    = 1'b1;
        b_wdata = desc_nxt;
      end
      rtcr_pkg::S_WINFO: begin
        b_addr  = ram_at(`RTCR_INFO_BASE, {4'h0, cmd_r[10:5]});
        b_we    = 1'b1;
        b_wdata = {16'h0000, info_r};
      end
      rtcr_pkg::S_IDLE, rtcr_pkg::S_DECIDE, rtcr_pkg::S_TXST,
      rtcr_pkg::S_TXLD, rtcr_pkg::S_TXDW: b_we = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r       <= rtcr_pkg::S_IDLE;
      cmd_r         <= 16'h0000;
      broadcast_flag_r       <= 1'b0;
      illegal_r     <= 1'b0;
      desc_r        <= 32'h0000_0000;
      idx_r         <= 6'h00;
      status_word_r <= 16'h0000;
      info_r        <= 16'h0000;
      tx_word_r     <= 16'h0000;
      tx_valid_r    <= 1'b0;
      ixz_hit_r     <= 1'b0;
    end else begin
      unique case (state_r)
        rtcr_pkg::S_IDLE: begin
          if (accept) begin
            cmd_r   <= cmd_word_in;
            broadcast_flag_r <= (cmd_word_in[15:11] == `RTCR_BROADCAST_FLAG_ADDR);
            state_r <= rtcr_pkg::S_RDESC;
          end
        end
        rtcr_pkg::S_RDESC: state_r <= rtcr_pkg::S_RILL;
        rtcr_pkg::S_RILL: begin
          desc_r  <= b_rdata;
          state_r <= rtcr_pkg::S_DECIDE;
        end
        rtcr_pkg::S_DECIDE: begin
          idx_r <= 6'h00;
          if (cmd_r[10] && broadcast_flag_r) begin
            illegal_r     <= 1'b0;
            status_word_r <= sw_fn(ta_s2_r, 1'b1, 1'b1);
            info_r        <= info_fn(1'b1, 1'b0, bus_identifier_in, 1'b1);
            state_r       <= rtcr_pkg::S_WDESC;
          end else if (cmd_r[10]) begin
            illegal_r     <= illegal_now;
            status_word_r <= sw_fn(ta_s2_r, illegal_now, 1'b0);
            info_r        <= info_fn(illegal_now, illegal_now, bus_identifier_in, 1'b0);
            tx_word_r     <= sw_fn(ta_s2_r, illegal_now, 1'b0);
            tx_valid_r    <= 1'b1;
            state_r       <= rtcr_pkg::S_TXST;
          end else begin
            illegal_r     <= illegal_now;
            status_word_r <= sw_fn(ta_s2_r, illegal_now, broadcast_flag_r);
            info_r        <= info_fn(illegal_now, illegal_now, bus_identifier_in, broadcast_flag_r);
            state_r       <= rtcr_pkg::S_RXDAT;
          end
        end
        rtcr_pkg::S_RXDAT: begin
          if (msg_done_in) begin
            idx_r <= 6'h00;
            if (broadcast_flag_r) begin
              state_r <= illegal_r ? rtcr_pkg::S_WDESC : rtcr_pkg::S_CPRD;
            end else begin
              tx_word_r  <= status_word_r;
              tx_valid_r <= 1'b1;
              state_r    <= rtcr_pkg::S_TXST;
            end
          end else if (rx_valid_in && idx_r < nwords(cmd_r[4:0])) begin
            idx_r <= idx_r + 6'h01;
          end
        end
        rtcr_pkg::S_TXST: begin
          if (tx_ready_in) begin
            tx_valid_r <= 1'b0;
            if (illegal_r) begin
              state_r <= rtcr_pkg::S_WDESC;
            end else begin
              state_r <= cmd_r[10] ? rtcr_pkg::S_TXRD : rtcr_pkg::S_CPRD;
            end
          end
        end
        rtcr_pkg::S_TXRD: state_r <= rtcr_pkg::S_TXLD;
        rtcr_pkg::S_TXLD: begin
          tx_word_r  <= b_rdata[15:0];
          tx_valid_r <= 1'b1;
          state_r    <= rtcr_pkg::S_TXDW;
        end
        rtcr_pkg::S_TXDW: begin
          if (tx_ready_in) begin
            tx_valid_r <= 1'b0;
            idx_r      <= idx_r + 6'h01;
            state_r    <= last_word ? rtcr_pkg::S_WDESC : rtcr_pkg::S_TXRD;
          end
        end
        rtcr_pkg::S_CPRD: state_r <= rtcr_pkg::S_CPWR;
        rtcr_pkg::S_CPWR: begin
          idx_r   <= idx_r + 6'h01;
          state_r <= last_word ? rtcr_pkg::S_WDESC : rtcr_pkg::S_CPRD;
        end
        rtcr_pkg::S_WDESC: begin
          ixz_hit_r <= (desc_r[`RTCR_DESC_IDX_HI:`RTCR_DESC_IDX_LO] == 8'h01);
          desc_r    <= desc_nxt;
          state_r   <= rtcr_pkg::S_WINFO;
        end
        rtcr_pkg::S_WINFO: state_r <= rtcr_pkg::S_IDLE;
      endcase
    end
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = hready_r;
  assign hresp_out     = hresp_r;
  assign tx_valid_out  = tx_valid_r;
  assign tx_word_out   = tx_word_r;
  assign irq_out       = irq_r;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  chk_err_cmd_ignored: assert property (
    (state_r == rtcr_pkg::S_IDLE) && cmd_valid_in && cmd_error_in
    |=> (state_r == rtcr_pkg::S_IDLE) && $stable(status_word_r))
    else $error("Errored command word was acted on");
  chk_broadcast_flag_disabled: assert property (
    (state_r == rtcr_pkg::S_IDLE) && cmd_valid_in && cfg_r[`RTCR_CFG_BROADCAST_FLAG_DIS]
    && (cmd_word_in[15:11] == `RTCR_BROADCAST_FLAG_ADDR) |=> (state_r == rtcr_pkg::S_IDLE))
    else $error("Broadcast accepted while disabled");
  chk_parity_blocks: assert property (
    (state_r == rtcr_pkg::S_IDLE) && cmd_valid_in && apf_fail
    |=> (state_r == rtcr_pkg::S_IDLE) && !tx_valid_r)
    else $error("Command accepted with address parity failure");
  chk_parity_irq: assert property (
    ev_apf |=> sts_r[`RTCR_IRQ_APF] ##1 irq_r)
    else $error("Address parity failure did not interrupt");
  chk_broadcast_flag_tx_silent: assert property (
    (state_r == rtcr_pkg::S_DECIDE) && cmd_r[10] && broadcast_flag_r
    |=> !tx_valid_r && status_word_r[`RTCR_SW_MSG_ERR] && status_word_r[`RTCR_SW_BC_RCVD]
        && info_r[`RTCR_INFO_MSG_ERR])
    else $error("Broadcast transmit answered or flags wrong");
  chk_legal_tx_clear: assert property (
    (state_r == rtcr_pkg::S_DECIDE) && cmd_r[10] && !broadcast_flag_r && !illegal_now
    |=> tx_valid_r && (tx_word_r == {ta_s2_r, 11'h000}) && (info_r[2:0] == 3'h0))
    else $error("Legal transmit status not clear");
  chk_illegal_tx_only_sw: assert property (
    (state_r == rtcr_pkg::S_TXST) && illegal_r && tx_ready_in
    |=> (state_r == rtcr_pkg::S_WDESC) ##1 (state_r == rtcr_pkg::S_WINFO) ##1
        (state_r == rtcr_pkg::S_IDLE) && !tx_valid_r && sts_r[`RTCR_IRQ_ILLEGAL])
    else $error("Illegal transmit sent data or missed interrupt");
  chk_rx_commit_late: assert property (
    b_we && b_addr[10] |-> (state_r == rtcr_pkg::S_CPWR))
    else $error("Buffer written before message completion");
  chk_ill_when_off: assert property (
    (state_r == rtcr_pkg::S_DECIDE) && !cfg_r[`RTCR_CFG_ILL_EN] |=> !illegal_r)
    else $error("Illegal table used while detection is off");
  chk_desc_toggle: assert property (
    (state_r == rtcr_pkg::S_WDESC) |-> b_we && b_wdata[`RTCR_DESC_ACC]
      && (b_wdata[`RTCR_DESC_PPB] != desc_r[`RTCR_DESC_PPB])
      && (b_wdata[`RTCR_DESC_BROADCAST_FLAG] == broadcast_flag_r))
    else $error("Descriptor control word update wrong");
endmodule // rtcr_top

/* File: tb/rtcr_bc_model.sv */
`timescale 1ns/1ps
module rtcr_bc_model (
  input  wire logic        mclk_in,
  output logic             cmd_valid_out,
  output logic [15:0]      cmd_word_out,
  output logic             cmd_error_out,
  output logic             rx_valid_out,
  output logic [15:0]      rx_word_out,
  output logic             msg_done_out,
  input  wire logic        tx_valid_in,
  input  wire logic [15:0] tx_word_in,
  output logic             tx_ready_out
);
  logic [15:0] got_q[$];
  logic        slow = 1'h0;
  initial begin
    cmd_valid_out = 1'h0;
    cmd_word_out = 16'h0000;
    cmd_error_out = 1'h0;
    rx_valid_out = 1'h0;
    rx_word_out = 16'h0000;
    msg_done_out = 1'h0;
    tx_ready_out = 1'h1;
  end
  // Slow mode takes a word only every other cycle
  always @(posedge mclk_in) begin
    tx_ready_out <= !slow || !tx_ready_out;
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_word_in);
  end
  // Idle word lines show the inverse so stale values cannot pass
  task automatic cmd(input logic [15:0] w, input logic e);
    @(posedge mclk_in);
    cmd_valid_out <= 1'h1;
    cmd_word_out <= w;
    cmd_error_out <= e;
    @(posedge mclk_in);
    cmd_valid_out <= 1'h0;
    cmd_word_out <= ~w;
    cmd_error_out <= 1'h0;
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic rx(input logic [15:0] w);
    rx_valid_out <= 1'h1;
    rx_word_out <= w;
    @(posedge mclk_in);
    rx_valid_out <= 1'h0;
    rx_word_out <= ~w;
    @(posedge mclk_in);
  endtask
  task automatic done;
    msg_done_out <= 1'h1;
    @(posedge mclk_in);
    msg_done_out <= 1'h0;
  endtask
endmodule // rtcr_bc_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [4:0]  ta = 5'h05;
  logic        tap = 1'h1;
  logic        bid = 1'h1;
  logic [31:0] hrdata, rd;
  logic        hready, hresp, cv, ce, rv, md, tv, tr, irq;
  logic [15:0] cw, rw, tw;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #2 clk = ~clk;
  rtcr_top i_dut (.mclk_in(clk), .sys_rst_in(rst), .hsel_in(1'h1), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .terminal_address_inputs_in(ta), .terminal_address_parity_in(tap), .cmd_valid_in(cv),
    .cmd_word_in(cw), .cmd_error_in(ce), .bus_identifier_in(bid), .rx_valid_in(rv),
    .rx_word_in(rw), .msg_done_in(md), .tx_valid_out(tv), .tx_word_out(tw),
    .tx_ready_in(tr), .irq_out(irq));
  rtcr_bc_model i_bc (.mclk_in(clk), .cmd_valid_out(cv), .cmd_word_out(cw),
    .cmd_error_out(ce), .rx_valid_out(rv), .rx_word_out(rw), .msg_done_out(md),
    .tx_valid_in(tv), .tx_word_in(tw), .tx_ready_out(tr));
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      report_and_stop;
    end
  end
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ahb(1'h1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, e, input string m);
    ahb(1'h0, a, 32'h0000_0000);
    chk(rd, e, m);
    chk({31'h0, hresp}, 32'h0000_0000, "hresp okay");
  endtask
  // Fixed settling time also catches words that arrive late
  task automatic txw(input int n, input logic [15:0] a, b);
    repeat (30) @(posedge clk);
    chk(i_bc.got_q.size(), n, "word count");
    if (n > 0) chk({16'h0000, i_bc.got_q[0]}, {16'h0000, a}, "word 0");
    if (n > 1) chk({16'h0000, i_bc.got_q[1]}, {16'h0000, b}, "word 1");
    i_bc.got_q.delete();
  endtask
  task automatic t_regs;
    rdc(32'h0000_0000, 32'h0000_0000, "config reset");
    wr(32'h0000_0000, 32'h0000_001F);
    rdc(32'h0000_0000, 32'h0000_001F, "config rw");
    rdc(32'h0000_0100, 32'h0000_0000, "unmapped");
    wr(32'h0000_0000, 32'h0000_0004);
    wr(32'h0000_0008, 32'h0000_0004);
    ahb(1'h0, 32'h0000_0004, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_tx;
    wr(32'h0000_2088, 32'h0001_0000);
    wr(32'h0000_3080, 32'h0000_BEEF);
    i_bc.cmd(16'h2C41, 1'h0);
    txw(2, 16'h2800, 16'hBEEF);
    rdc(32'h0000_2088, 32'h0001_0003, "tx desc");
    rdc(32'h0000_2188, 32'h0000_0008, "tx info");
    chk({31'h0, irq}, 32'h0000_0001, "access irq");
    rdc(32'h0000_0004, 32'h0000_0004, "access status");
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    $display("test legal transmit done");
  endtask
  task automatic t_ill;
    i_bc.slow = 1'h1;
    wr(32'h0000_2204, 32'h0000_0004);
    i_bc.cmd(16'h2C41, 1'h0);
    txw(2, 16'h2800, 16'hBEEF);
    wr(32'h0000_0000, 32'h0000_0006);
    i_bc.cmd(16'h2C41, 1'h0);
    txw(1, 16'h2C00, 16'h0000);
    rdc(32'h0000_2188, 32'h0000_000B, "ill info");
    ahb(1'h0, 32'h0000_0004, 32'h0000_0000);
    chk(rd & 32'h0000_0006, 32'h0000_0006, "ill status");
    i_bc.slow = 1'h0;
    $display("test illegal transmit done");
  endtask
  task automatic t_bc;
    wr(32'h0000_0000, 32'h0000_001C);
    i_bc.cmd(16'hFC41, 1'h0);
    txw(0, 16'h0000, 16'h0000);
    rdc(32'h0000_2088, 32'h0001_0005, "bc desc");
    rdc(32'h0000_2188, 32'h0000_0019, "bc info");
    rdc(32'h0000_000C, 32'h0000_2C10, "bc status word");
    rdc(32'h0000_0010, 32'h0000_0019, "bc last info");
    $display("test broadcast transmit done");
  endtask
  task automatic t_rx;
    wr(32'h0000_2200, 32'h0000_0000);
    bid <= 1'h0;
    wr(32'h0000_200C, 32'h0002_0100);
    wr(32'h0000_3100, 32'h0000_0000);
    i_bc.cmd(16'h2862, 1'h0);
    i_bc.rx(16'h1234);
    i_bc.rx(16'h5678);
    rdc(32'h0000_3100, 32'h0000_0000, "early commit");
    i_bc.done;
    txw(1, 16'h2800, 16'h0000);
    rdc(32'h0000_3100, 32'h0000_1234, "rx word 0");
    rdc(32'h0000_3104, 32'h0000_5678, "rx word 1");
    rdc(32'h0000_200C, 32'h0002_0003, "rx desc");
    rdc(32'h0000_210C, 32'h0000_0000, "rx info");
    $display("test legal receive done");
  endtask
  task automatic t_ign;
    i_bc.cmd(16'h2C41, 1'h1);
    txw(0, 16'h0000, 16'h0000);
    wr(32'h0000_0000, 32'h0000_0001);
    i_bc.cmd(16'hFC41, 1'h0);
    txw(0, 16'h0000, 16'h0000);
    wr(32'h0000_0000, 32'h0000_0000);
    rdc(32'h0000_0004, 32'h0000_003C, "optional irqs");
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000, "irq idle");
    tap <= 1'h0;
    repeat (10) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001, "parity irq");
    i_bc.cmd(16'h2C41, 1'h0);
    i_bc.cmd(16'hFC41, 1'h0);
    txw(0, 16'h0000, 16'h0000);
    ahb(1'h0, 32'h0000_0004, 32'h0000_0000);
    chk(rd & 32'h0000_0001, 32'h0000_0001, "parity status");
    tap <= 1'h1;
    repeat (10) @(posedge clk);
    rdc(32'h0000_2088, 32'h0001_0005, "desc kept");
    rdc(32'h0000_2188, 32'h0000_0019, "info kept");
    rdc(32'h0000_000C, 32'h0000_2800, "status kept");
    $display("test ignored commands done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    t_regs;
    t_tx;
    t_ill;
    t_bc;
    t_rx;
    t_ign;
    report_and_stop;
  end
endmodule // tb_top
